// ### design/txrb_consts.svh
// Offsets, field positions and reset values of the transmit register bank
`ifndef TXRB_CONSTS_SVH
`define TXRB_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TXRB_OFS_RECONFIG_CTRL   12'h060
`define TXRB_OFS_RECONFIG_STAT   12'h064
`define TXRB_OFS_CONFIG          12'h068
`define TXRB_OFS_TX_CTRL         12'h070
`define TXRB_OFS_TX_BYPASS       12'h074
`define TXRB_OFS_TX_STAT         12'h078
`define TXRB_RESET_VALUE         32'h0000_0000

// ****************************************************************
// Common control and status fields
// ****************************************************************
`define TXRB_CC_ADDR_HI          11
`define TXRB_CC_ADDR_LO          0
`define TXRB_CC_ENABLE           12
`define TXRB_CC_WRITE            13
`define TXRB_CC_DATA_HI          31
`define TXRB_CC_DATA_LO          16
`define TXRB_CS_DATA_HI          15
`define TXRB_CS_READY            16
`define TXRB_CS_BUSY             17
`define TXRB_CFG_HDMI            0

// ****************************************************************
// Per-lane byte layout
// ****************************************************************
`define TXRB_LANES               4
`define TXRB_LANE_STRIDE         8
`define TXRB_TC_LINE_CODE        0
`define TXRB_TC_INVERT           1
`define TXRB_TC_PAT_HI           4
`define TXRB_TC_PAT_LO           2
`define TXRB_TC_FORCE_ERR        5
`define TXRB_TC_PAT_EXTRA        6
`define TXRB_TC_USED_MASK        8'h7f
`define TXRB_TS_ALIGN_DONE       0
`define TXRB_TS_INIT_DONE        1
`define TXRB_TS_DLY_RST_DONE     2
`define TXRB_TS_BUF_HI           4
`define TXRB_TS_BUF_LO           3
`define TXRB_TS_FAULT            5
`define TXRB_PATTERN_PRBS31      3'h4
`define TXRB_TS_USED_MASK        8'h3f
`define TXRB_PAT_W               3
`define TXRB_BUF_W               2
`define TXRB_BB_PH_DLY_RST       0
`define TXRB_BB_PH_ALIGN         1
`define TXRB_BB_PH_ALIGN_EN      2
`define TXRB_BB_PH_DLY_PD        3
`define TXRB_BB_PH_INIT          4
`define TXRB_BB_DLY_RST          5
`define TXRB_BB_DLY_BYPASS       6
`define TXRB_BB_DLY_EN           7

// ****************************************************************
// Bus encodings
// ****************************************************************
`define TXRB_HTRANS_NONSEQ_BIT   1
`define TXRB_HRESP_OKAY          1'h0
`define TXRB_ADDR_W              12
`define TXRB_WORD_LSB            2

`endif

// ### design/txrb_pkg.sv
// Types shared by the transmit register bank
package txrb_pkg;
  typedef enum logic [0:0] {
    TXRB_PORT_IDLE,
    TXRB_PORT_BUSY
  } txrb_port_state_type;

  typedef logic [7:0] txrb_lane_byte_type;
endpackage

// ### design/txrb_lane.sv
// One transmit lane: gated control byte outputs and synchronised status byte
`timescale 1ns/1ps
`include "txrb_consts.svh"

module txrb_lane
  import txrb_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire txrb_lane_byte_type ctrl_byte_in,
  input  wire txrb_lane_byte_type bypass_byte_in,
  input  wire logic               hdmi_mode_in,
  input  wire txrb_lane_byte_type status_raw_in,
  output txrb_lane_byte_type      ctrl_out,
  output txrb_lane_byte_type      bypass_out,
  output txrb_lane_byte_type      status_out
);

  txrb_lane_byte_type ctrl_d;
  txrb_lane_byte_type bypass_d;
  txrb_lane_byte_type sync1_q;
  txrb_lane_byte_type sync2_q;
  txrb_lane_byte_type ctrl_q;
  txrb_lane_byte_type bypass_q;
  txrb_lane_byte_type status_mask;

  // ****************************************************************
  // Control gating
  // ****************************************************************
  // Line coding enable is meaningless under HDMI, so it is held off there
  assign ctrl_d = (ctrl_byte_in & `TXRB_TC_USED_MASK) &
                  ~(txrb_lane_byte_type'(hdmi_mode_in) << `TXRB_TC_LINE_CODE);
  // The transceiver sequences bypass itself under DisplayPort
  assign bypass_d = hdmi_mode_in ? bypass_byte_in : 8'h00;

  // ****************************************************************
  // Status: two flops from the transceiver domain; reserved bits zero
  // ****************************************************************
  assign status_mask = `TXRB_TS_USED_MASK;
  assign status_out  = sync2_q & status_mask;
  assign ctrl_out    = ctrl_q;
  assign bypass_out  = bypass_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q  <= 8'h00;
      sync2_q  <= 8'h00;
      ctrl_q   <= 8'h00;
      bypass_q <= 8'h00;
    end else begin
      sync1_q  <= status_raw_in;
      sync2_q  <= sync1_q;
      ctrl_q   <= ctrl_d;
      bypass_q <= bypass_d;
    end
  end

endmodule

// ### design/txrb_top.sv
// Transmit register bank: AHB-Lite slave, reconfiguration port, lane control
`timescale 1ns/1ps
`include "txrb_consts.svh"

module txrb_top
  import txrb_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [11:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  // Reconfiguration port
  output logic [11:0]      reconfig_address_out,
  output logic             reconfig_enable_out,
  output logic             reconfig_write_enable_out,
  output logic [15:0]      reconfig_write_data_out,
  input  wire logic [15:0] reconfig_read_data_in,
  input  wire logic        reconfig_ready_in,
  // Lane controls, one bit per lane except pattern select, which takes three bits per lane
  output logic [3:0]       tx_line_code_enable_out,
  output logic [3:0]       tx_invert_output_out,
  output logic [11:0]      tx_pattern_select_out,
  output logic [3:0]       tx_pattern_force_error_out,
  output logic [3:0]       tx_pattern_select_extra_out,
  output logic [3:0]       tx_phase_delay_reset_out,
  output logic [3:0]       tx_phase_align_out,
  output logic [3:0]       tx_phase_align_enable_out,
  output logic [3:0]       tx_phase_delay_powerdown_out,
  output logic [3:0]       tx_phase_init_out,
  output logic [3:0]       tx_delay_reset_out,
  output logic [3:0]       tx_delay_bypass_out,
  output logic [3:0]       tx_delay_enable_out,
  // Lane status from the transceivers, asynchronous
  input  wire logic [3:0]  tx_phase_align_done_in,
  input  wire logic [3:0]  tx_phase_init_done_in,
  input  wire logic [3:0]  tx_delay_reset_done_in,
  input  wire logic [7:0]  tx_buffer_state_in,
  input  wire logic [3:0]  tx_bypass_fault_in
);

  // ****************************************************************
  // Bus address phase
  // ****************************************************************
  logic                 wr_pend_q;
  logic                 rd_pend_q;
  logic [11:0]          addr_q;
  logic [31:0]          hrdata_q;
  logic [31:0]          rd_mux;
  wire                  take = hsel_in & hready_in & htrans_in[`TXRB_HTRANS_NONSEQ_BIT];
  wire  [11:0]          word_addr = {addr_q[11:`TXRB_WORD_LSB], 2'h0};

  // Reads wait one cycle so that a write just before is already visible
  assign hreadyout_out = ~rd_pend_q;
  assign hresp_out     = `TXRB_HRESP_OKAY;
  assign hrdata_out    = hrdata_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 12'h000;
      hrdata_q  <= `TXRB_RESET_VALUE;
    end else begin
      wr_pend_q <= take & hwrite_in;
      rd_pend_q <= take & ~hwrite_in;
      if (take) begin
        addr_q <= haddr_in;
      end
      if (rd_pend_q) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  wire wr_cc   = wr_pend_q & (word_addr == `TXRB_OFS_RECONFIG_CTRL);
  wire wr_cfg  = wr_pend_q & (word_addr == `TXRB_OFS_CONFIG);
  wire wr_ctrl = wr_pend_q & (word_addr == `TXRB_OFS_TX_CTRL);
  wire wr_byp  = wr_pend_q & (word_addr == `TXRB_OFS_TX_BYPASS);

  logic [31:0] cc_q;
  logic        hdmi_q;
  logic [31:0] tx_ctrl_q;
  logic [31:0] tx_byp_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cc_q      <= `TXRB_RESET_VALUE;
      hdmi_q    <= 1'b0;
      tx_ctrl_q <= `TXRB_RESET_VALUE;
      tx_byp_q  <= `TXRB_RESET_VALUE;
    end else begin
      if (wr_cc) begin
        cc_q <= hwdata_in;
      end
      if (wr_cfg) begin
        hdmi_q <= hwdata_in[`TXRB_CFG_HDMI];
      end
      if (wr_ctrl) begin
        tx_ctrl_q <= hwdata_in;
      end
      if (wr_byp) begin
        tx_byp_q <= hwdata_in;
      end
    end
  end

  // ****************************************************************
  // Reconfiguration port sequencer
  // ****************************************************************
  txrb_port_state_type state_q;
  txrb_port_state_type state_d;
  logic                ready_q;
  logic [15:0]         rdata_q;
  logic                is_read_q;
  logic                en_pulse_q;
  logic [11:0]         raddr_q;
  logic                rwe_q;
  logic [15:0]         rwdata_q;

  // ****************************************************************
  // Common control word fields, taken straight from the data phase
  // ****************************************************************
  wire [11:0] cc_addr   = hwdata_in[`TXRB_CC_ADDR_HI:`TXRB_CC_ADDR_LO];
  wire        cc_enable = hwdata_in[`TXRB_CC_ENABLE];
  wire        cc_write  = hwdata_in[`TXRB_CC_WRITE];
  wire [15:0] cc_data   = hwdata_in[`TXRB_CC_DATA_HI:`TXRB_CC_DATA_LO];
  wire        port_busy = (state_q == TXRB_PORT_BUSY);

  // A launch while busy is dropped; cc_q still updates but the port fields keep their values
  wire launch = wr_cc & cc_enable & ~port_busy;
  wire done   = port_busy & reconfig_ready_in;

  always_comb begin
    state_d = state_q;
    case (state_q)
      TXRB_PORT_IDLE: begin
        if (launch) begin
          state_d = TXRB_PORT_BUSY;
        end
      end
      TXRB_PORT_BUSY: begin
        if (reconfig_ready_in) begin
          state_d = TXRB_PORT_IDLE;
        end
      end
      default: begin
        state_d = TXRB_PORT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q    <= TXRB_PORT_IDLE;
      ready_q    <= 1'b0;
      rdata_q    <= 16'h0000;
      is_read_q  <= 1'b0;
      en_pulse_q <= 1'b0;
      raddr_q    <= 12'h000;
      rwe_q      <= 1'b0;
      rwdata_q   <= 16'h0000;
    end else begin
      state_q    <= state_d;
      en_pulse_q <= launch;
      if (launch) begin
        raddr_q   <= cc_addr;
        rwe_q     <= cc_write;
        rwdata_q  <= cc_data;
        is_read_q <= ~cc_write;
      end
      // Completion wins over the clear that a new launch brings
      if (done) begin
        ready_q <= 1'b1;
      end else if (launch) begin
        ready_q <= 1'b0;
      end
      if (done & is_read_q) begin
        rdata_q <= reconfig_read_data_in;
      end
    end
  end

  // ****************************************************************
  // Reconfiguration port outputs and common status word
  // ****************************************************************
  // Fields stay registered so the port sees them stable for the whole transfer
  assign reconfig_address_out      = raddr_q;
  assign reconfig_enable_out       = en_pulse_q;
  assign reconfig_write_enable_out = rwe_q;
  assign reconfig_write_data_out   = rwdata_q;

  // Reserved bits are tied low; software must not rely on them
  wire [13:0] cs_reserved = 14'h0000;
  wire [31:0] cs_word     = {cs_reserved, port_busy, ready_q, rdata_q};
  wire [31:0] cfg_word    = {31'h0000_0000, hdmi_q};

  // ****************************************************************
  // Lanes
  // ****************************************************************
  logic [31:0] ctrl_lanes;
  logic [31:0] byp_lanes;
  logic [31:0] stat_lanes;

  genvar g;
  generate
    for (g = 0; g < `TXRB_LANES; g = g + 1) begin : gen_lane
      localparam int B = g * `TXRB_LANE_STRIDE;
      txrb_lane_byte_type raw_status;
      // Status levels come from the transceiver clocks; the lane synchronises them
      assign raw_status = {2'h0, tx_bypass_fault_in[g],
                           tx_buffer_state_in[`TXRB_BUF_W*g +: `TXRB_BUF_W],
                           tx_delay_reset_done_in[g], tx_phase_init_done_in[g],
                           tx_phase_align_done_in[g]};
      txrb_lane u_lane (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .ctrl_byte_in   (tx_ctrl_q[B +: 8]),
        .bypass_byte_in (tx_byp_q[B +: 8]),
        .hdmi_mode_in   (hdmi_q),
        .status_raw_in  (raw_status),
        .ctrl_out       (ctrl_lanes[B +: 8]),
        .bypass_out     (byp_lanes[B +: 8]),
        .status_out     (stat_lanes[B +: 8])
      );
      assign tx_line_code_enable_out[g]     = ctrl_lanes[B + `TXRB_TC_LINE_CODE];
      assign tx_invert_output_out[g]        = ctrl_lanes[B + `TXRB_TC_INVERT];

      // ****************************************************************
      // Lane control outputs
      // ****************************************************************
      assign tx_pattern_select_out[`TXRB_PAT_W*g +: `TXRB_PAT_W] =
        ctrl_lanes[B + `TXRB_TC_PAT_LO +: `TXRB_PAT_W];
      assign tx_pattern_force_error_out[g]  = ctrl_lanes[B + `TXRB_TC_FORCE_ERR];
      assign tx_pattern_select_extra_out[g] = ctrl_lanes[B + `TXRB_TC_PAT_EXTRA];

      // ****************************************************************
      // Buffer-bypass sequencing outputs
      // ****************************************************************
      // Software owns the sequence order; nothing here checks that it is sane
      assign tx_phase_delay_reset_out[g]     = byp_lanes[B + `TXRB_BB_PH_DLY_RST];
      assign tx_phase_align_out[g]           = byp_lanes[B + `TXRB_BB_PH_ALIGN];
      assign tx_phase_align_enable_out[g]    = byp_lanes[B + `TXRB_BB_PH_ALIGN_EN];
      assign tx_phase_delay_powerdown_out[g] = byp_lanes[B + `TXRB_BB_PH_DLY_PD];
      assign tx_phase_init_out[g]            = byp_lanes[B + `TXRB_BB_PH_INIT];
      assign tx_delay_reset_out[g]           = byp_lanes[B + `TXRB_BB_DLY_RST];
      assign tx_delay_bypass_out[g]          = byp_lanes[B + `TXRB_BB_DLY_BYPASS];
      assign tx_delay_enable_out[g]          = byp_lanes[B + `TXRB_BB_DLY_EN];
    end
  endgenerate

  // ****************************************************************
  // Read decode; unmapped words read zero
  // ****************************************************************
  always_comb begin
    if (word_addr == `TXRB_OFS_RECONFIG_CTRL) begin
      rd_mux = cc_q;
    end else if (word_addr == `TXRB_OFS_RECONFIG_STAT) begin
      rd_mux = cs_word;
    end else if (word_addr == `TXRB_OFS_CONFIG) begin
      rd_mux = cfg_word;
    end else if (word_addr == `TXRB_OFS_TX_CTRL) begin
      rd_mux = tx_ctrl_q;
    end else if (word_addr == `TXRB_OFS_TX_BYPASS) begin
      rd_mux = tx_byp_q;
    end else if (word_addr == `TXRB_OFS_TX_STAT) begin
      rd_mux = stat_lanes;
    end else begin
      rd_mux = `TXRB_RESET_VALUE;
    end
  end

endmodule

// ### verif/txrb_monitor.sv
// Port checks for the transmit register bank
`timescale 1ns/1ps
module txrb_monitor (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        hsel_in,
  input wire logic [11:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire logic [11:0] reconfig_address_out,
  input wire logic        reconfig_enable_out,
  input wire logic [15:0] reconfig_write_data_out,
  input wire logic [3:0]  tx_line_code_enable_out,
  input wire logic [3:0]  tx_invert_output_out,
  input wire logic [3:0]  tx_phase_delay_reset_out,
  input wire logic [3:0]  tx_delay_enable_out
);
  // ****
  // Data phase tracking
  // ****
  wire        take = hsel_in & hready_in & htrans_in[1];
  logic       ph_q;
  logic       wr_q;
  logic       hdmi_q;
  logic [9:0] a_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ph_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 10'h0;
      hdmi_q <= 1'b0;
    end else begin
      if (ph_q && wr_q && a_q == 10'h1a && hready_in) hdmi_q <= hwdata_in[0];
      if (hready_in) begin
        ph_q <= take;
        wr_q <= hwrite_in;
        a_q <= haddr_in[11:2];
      end
    end
  end
  // Word index only: byte lanes are never split
  wire wd = ph_q & wr_q & hready_in;
  wire rd = ph_q & ~wr_q & hreadyout_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  hresp_okay_a: assert property (!hresp_out) else $error("error response seen");
  read_wait_a: assert property (take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  write_wait_a: assert property (take && hwrite_in |=> hreadyout_out) else $error("write stalled");
  status_res_a: assert property (rd && a_q == 10'h19 |-> hrdata_out[31:18] == 14'h0)
    else $error("status reserved bits set");
  lane_res_a: assert property (rd && a_q == 10'h1e |-> (hrdata_out & 32'hc0c0_c0c0) == 32'h0)
    else $error("lane status reserved bits set");
  enable_pulse_a: assert property (reconfig_enable_out |=> !reconfig_enable_out)
    else $error("enable longer than one cycle");
  launch_a: assert property (reconfig_enable_out |-> $past(wd && a_q == 10'h18 && hwdata_in[12])
    && reconfig_address_out == $past(hwdata_in[11:0])
    && reconfig_write_data_out == $past(hwdata_in[31:16])) else $error("launch fields wrong");
  invert_a: assert property (wd && a_q == 10'h1c |-> ##2 tx_invert_output_out ==
    {$past(hwdata_in[25], 2), $past(hwdata_in[17], 2), $past(hwdata_in[9], 2),
     $past(hwdata_in[1], 2)}) else $error("invert bits do not follow control");
  bypass_gate_a: assert property (!hdmi_q && !$past(hdmi_q) |->
    (tx_phase_delay_reset_out | tx_delay_enable_out) == 4'h0) else $error("bypass driven");
  line_gate_a: assert property (hdmi_q && $past(hdmi_q) |-> tx_line_code_enable_out == 4'h0)
    else $error("line coding enabled in hdmi mode");
endmodule
bind txrb_top txrb_monitor mon (.clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
  .hwdata_in, .hready_in, .hreadyout_out, .hresp_out, .hrdata_out, .reconfig_address_out,
  .reconfig_enable_out, .reconfig_write_data_out, .tx_line_code_enable_out,
  .tx_invert_output_out, .tx_phase_delay_reset_out, .tx_delay_enable_out);

// ### verif/txrb_reconfig_model.sv
// Behavioural reconfiguration port of the transceiver channels
`timescale 1ns/1ps
module txrb_reconfig_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [11:0] address_in,
  input  wire logic        enable_in,
  input  wire logic        write_enable_in,
  input  wire logic [15:0] write_data_in,
  input  wire logic [7:0]  delay_in,
  output logic [15:0]      read_data_out,
  output logic             ready_out,
  output logic [11:0]      last_address_out,
  output logic [15:0]      last_write_data_out,
  output logic             last_write_out,
  output logic [7:0]       launch_count_out
);
  // ****
  // Transfer engine
  // ****
  logic [7:0] wait_q;
  logic       pend_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {read_data_out, ready_out, last_address_out, last_write_data_out} <= '0;
      {last_write_out, launch_count_out, wait_q, pend_q} <= '0;
    end else begin
      ready_out <= 1'b0;
      // Read data toggles outside its ready cycle so a late capture is caught
      read_data_out <= ~read_data_out;
      if (enable_in) begin
        last_address_out <= address_in;
        last_write_data_out <= write_data_in;
        last_write_out <= write_enable_in;
        launch_count_out <= launch_count_out + 8'h1;
        wait_q <= delay_in;
        pend_q <= 1'b1;
      end else if (pend_q) begin
        if (wait_q == 8'h0) begin
          ready_out <= 1'b1;
          pend_q <= 1'b0;
          if (!last_write_out) read_data_out <= {4'hc, last_address_out};
        end else begin
          wait_q <= wait_q - 8'h1;
        end
      end
    end
  end
endmodule

// ### verif/tb_transceiver_tx_register_bank.sv
// Self-checking bench for the transmit register bank
`timescale 1ns/1ps
module tb_transceiver_tx_register_bank;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        hsel_in = 1'b0;
  logic        hwrite_in = 1'b0;
  logic [1:0]  htrans_in = 2'h0;
  logic [11:0] haddr_in = 12'h0;
  logic [31:0] hwdata_in = 32'h0;
  logic [31:0] hrdata_out, rv, e;
  logic        hreadyout_out, hresp_out, ren, rwe, rrdy, last_w;
  logic [11:0] raddr, pat, last_a;
  logic [15:0] rwd, rrd, last_d;
  logic [7:0]  dly = 8'h0, buf_st = 8'h0, cnt, n;
  logic [3:0]  al = 4'h0, idn = 4'h0, rdn = 4'h0, flt = 4'h0;
  logic [3:0]  lce, inv, fe, ex, pdr, pa, pae, pdp, pi, dr, db, de;
  logic [31:0] tv[2] = '{32'h3a4f_8db1, 32'hc5b0_724e};
  logic [7:0]  dl[2] = '{8'd20, 8'd0};
  int          bad_count = 0;
  int          checks = 0;
  always #12.5 clk_in = ~clk_in;
  txrb_top dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .hrdata_out(hrdata_out), .reconfig_address_out(raddr), .reconfig_enable_out(ren),
    .reconfig_write_enable_out(rwe), .reconfig_write_data_out(rwd),
    .reconfig_read_data_in(rrd), .reconfig_ready_in(rrdy), .tx_line_code_enable_out(lce),
    .tx_invert_output_out(inv), .tx_pattern_select_out(pat), .tx_pattern_force_error_out(fe),
    .tx_pattern_select_extra_out(ex), .tx_phase_delay_reset_out(pdr), .tx_phase_align_out(pa),
    .tx_phase_align_enable_out(pae), .tx_phase_delay_powerdown_out(pdp),
    .tx_phase_init_out(pi), .tx_delay_reset_out(dr), .tx_delay_bypass_out(db),
    .tx_delay_enable_out(de), .tx_phase_align_done_in(al), .tx_phase_init_done_in(idn),
    .tx_delay_reset_done_in(rdn), .tx_buffer_state_in(buf_st), .tx_bypass_fault_in(flt));
  txrb_reconfig_model partner (.clk_in(clk_in), .rst_in(rst_in), .address_in(raddr),
    .enable_in(ren), .write_enable_in(rwe), .write_data_in(rwd), .delay_in(dly),
    .read_data_out(rrd), .ready_out(rrdy), .last_address_out(last_a),
    .last_write_data_out(last_d), .last_write_out(last_w), .launch_count_out(cnt));
  // ****
  // Bus and compare tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= w;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    if (w) hwdata_in <= d;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    rv = hrdata_out;
  endtask
  // Polling is bounded; a port that never frees shows up as a data mismatch
  task automatic poll;
    for (int k = 0; k < 40; k++) begin
      bus(1'b0, 12'h064, 32'h0);
      if (rv[17] === 1'b0) break;
    end
  endtask
  function automatic logic [31:0] exp_tx(input logic [31:0] c, input logic hdmi);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 4; i++) begin
      r[24+i] = c[8*i] & !hdmi;
      r[20+i] = c[8*i+1];
      r[16+i] = c[8*i+5];
      r[12+i] = c[8*i+6];
      r[3*i+:3] = c[8*i+2+:3];
    end
    return r;
  endfunction
  function automatic logic [31:0] exp_bb(input logic [31:0] c, input logic hdmi);
    logic [31:0] r;
    for (int k = 0; k < 32; k++) r[k] = c[8*(k%4)+k/4] & hdmi;
    return r;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    final_report;
  end
  // ****
  // Test sequence
  // ****
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    bus(1'b1, 12'h064, 32'hffff_ffff);
    bus(1'b1, 12'h0ac, 32'hffff_ffff);
    for (int j = 0; j < 5; j++) begin
      bus(1'b0, 12'h064 + 12'(j) * 12'h4 + (j > 0 ? 12'h8 : 12'h0), 32'h0);
      chk(rv, 32'h0);
    end
    bus(1'b0, 12'h0ac, 32'h0);
    chk(rv, 32'h0);
    $display("reset and read-only test done");
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, 12'h070, tv[j]);
      bus(1'b0, 12'h070, 32'h0);
      chk(rv, tv[j]);
      chk({4'h0, lce, inv, fe, ex, pat}, exp_tx(tv[j], 1'b0));
    end
    $display("lane control test done");
    bus(1'b1, 12'h074, 32'ha53c_e117);
    bus(1'b0, 12'h074, 32'h0);
    chk(rv, 32'ha53c_e117);
    chk({de, db, dr, pi, pdp, pae, pa, pdr}, exp_bb(32'ha53c_e117, 1'b0));
    bus(1'b1, 12'h068, 32'h1);
    bus(1'b0, 12'h070, 32'h0);
    chk({de, db, dr, pi, pdp, pae, pa, pdr}, exp_bb(32'ha53c_e117, 1'b1));
    chk({4'h0, lce, inv, fe, ex, pat}, exp_tx(tv[1], 1'b1));
    bus(1'b1, 12'h068, 32'h0);
    $display("buffer bypass test done");
    for (int j = 0; j < 2; j++) begin
      {al, idn, rdn, flt, buf_st} <= j ? ~24'h5ac39c : 24'h5ac39c;
      repeat (3) @(posedge clk_in);
      bus(1'b1, 12'h078, 32'hffff_ffff);
      bus(1'b0, 12'h078, 32'h0);
      for (int i = 0; i < 4; i++) e[8*i+:8] = {2'b00, flt[i], buf_st[2*i+:2], rdn[i], idn[i], al[i]};
      chk(rv, e);
    end
    $display("lane status test done");
    for (int j = 0; j < 2; j++) begin
      dly <= dl[j];
      n = cnt;
      bus(1'b1, 12'h060, 32'h0000_12a5);
      bus(1'b0, 12'h064, 32'h0);
      if (dl[j] != 8'h0) chk({30'h0, rv[17:16]}, 32'h2);
      poll;
      chk(rv, 32'h0001_c2a5);
      bus(1'b1, 12'h060, 32'hbeef_30f0);
      bus(1'b1, 12'h060, 32'h1234_3111);
      poll;
      chk(rv, 32'h0001_c2a5);
      chk({3'h0, last_w, last_a, last_d}, {3'h0, 1'b1, 12'h0f0, 16'hbeef});
      chk({24'h0, cnt - n}, 32'h2);
    end
    $display("reconfiguration port test done");
    final_report;
  end
endmodule
